// ---- rtl/lars_sequencer.sv ----
`include "lars_cfg.svh"

module lars_sequencer #(
	parameter int PIXELS = `LARS_PIXELS
) (
	// system
	input  wire logic                clk,
	input  wire logic                rst,
	// controller pins, asynchronous to clk
	input  wire logic                sensor_clk_pin,
	input  wire logic                frame_start_pin,
	// pixel routing
	output logic [PIXELS-1:0]        pixel_select,
	output logic [PIXELS-1:0]        sample_connect,
	output logic                     analog_pixel_out_en,
	// integration control and status
	output logic                     sample_freeze,
	output logic                     integrator_reset,
	output logic                     charge_transfer_wait,
	output lars_pkg::lars_count_t    clock_count
);
	import lars_pkg::*;

	logic                    sclk_s1;
	logic                    sclk_s2;
	logic                    sclk_d;
	logic                    fs_s1;
	logic                    fs_s2;
	logic                    fs_d;
	logic                    clock_edge;
	logic                    fs_rise;
	logic [PIXELS-1:0]       next_shift;
	lars_count_t             next_count;
	lars_state_t             state;
	logic [`LARS_WAIT_W-1:0] wait_cnt;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// two-stage synchronisers for the controller pins
	always_ff @(posedge clk) begin
		if (rst) begin
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_d  <= 1'b0;
			fs_s1   <= 1'b0;
			fs_s2   <= 1'b0;
			fs_d    <= 1'b0;
		end else begin
			sclk_s1 <= sensor_clk_pin;
			sclk_s2 <= sclk_s1;
			sclk_d  <= sclk_s2;
			fs_s1   <= frame_start_pin;
			fs_s2   <= fs_s1;
			fs_d    <= fs_s2;
		end
	end

	// edge detection after synchronisation
	assign clock_edge = sclk_s2 & ~sclk_d;
	assign fs_rise    = fs_s2 & ~fs_d;

	// shift register next value: start level enters pixel 1
	always_comb begin
		next_shift = {pixel_select[PIXELS-2:0], fs_s2};
	end

	// count of sensor clocks since the start bit entered
	always_comb begin
		next_count = clock_count;
		if (clock_edge) begin
			if (fs_s2) begin
				next_count = `LARS_CNT_FIRST;
			end else if (clock_count == `LARS_CNT_END) begin
				next_count = '0;
			end else if (clock_count != '0) begin
				next_count = clock_count + `LARS_CNT_FIRST;
			end
		end
	end

	// shift register and output enable, both moved on sensor edges
	always_ff @(posedge clk) begin
		if (rst) begin
			pixel_select        <= '0;
			analog_pixel_out_en <= 1'b0;
		end else if (clock_edge) begin
			pixel_select        <= next_shift;
			analog_pixel_out_en <= |next_shift;
		end
	end

	// clock counter
	always_ff @(posedge clk) begin
		if (rst) begin
			clock_count <= '0;
		end else begin
			clock_count <= next_count;
		end
	end

	// sample hold: raised by start edge, dropped once bit is captured
	always_ff @(posedge clk) begin
		if (rst) begin
			sample_freeze <= 1'b0;
		end else if (clock_edge && fs_s2) begin
			sample_freeze <= 1'b0;
		end else if (fs_rise) begin
			sample_freeze <= 1'b1;
		end
	end

	// integrator reset from start edge through the 18th clock
	always_ff @(posedge clk) begin
		if (rst) begin
			integrator_reset <= 1'b0;
		end else if (fs_rise) begin
			integrator_reset <= 1'b1;
		end else if (clock_edge && next_count == `LARS_CNT_INT_START) begin
			integrator_reset <= 1'b0;
		end
	end

	// per-pixel sampling switch: reconnect once read and integrating
	for (genvar i = 0; i < PIXELS; i++) begin : g_connect
		localparam lars_count_t READ_DONE = lars_count_t'(i + 2);
		always_ff @(posedge clk) begin
			if (rst) begin
				sample_connect[i] <= 1'b1;
			end else if (fs_rise) begin
				sample_connect[i] <= 1'b0;
			end else if (clock_edge && next_count >= `LARS_CNT_INT_START && next_count >= READ_DONE) begin
				sample_connect[i] <= 1'b1;
			end else if (clock_edge && next_count == '0 && !sample_freeze) begin
				sample_connect[i] <= 1'b1;
			end
		end
	end

	// phase machine
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= lars_st_idle;
		end else if (clock_edge && fs_s2) begin
			state <= lars_st_setup;
		end else begin
			case (state)
				lars_st_idle: begin
					state <= lars_st_idle;
				end
				lars_st_setup: begin
					if (clock_edge && next_count == `LARS_CNT_INT_START) begin
						state <= lars_st_readout;
					end
				end
				lars_st_readout: begin
					if (clock_edge && clock_count == `LARS_CNT_LAST_PIX) begin
						state <= lars_st_transfer;
					end
				end
				lars_st_transfer: begin
					if (wait_cnt == '0) begin
						state <= lars_st_idle;
					end
				end
				default: begin
					state <= lars_st_idle;
				end
			endcase
		end
	end

	// charge transfer wait counter, loaded at the 129th edge
	always_ff @(posedge clk) begin
		if (rst) begin
			wait_cnt <= '0;
		end else if (state == lars_st_readout && clock_edge && clock_count == `LARS_CNT_LAST_PIX) begin
			wait_cnt <= `LARS_WAIT_W'(`LARS_TQT_CYCLES - 32'h0000_0001);
		end else if (wait_cnt != '0) begin
			wait_cnt <= wait_cnt - `LARS_WAIT_W'(1);
		end
	end

	// busy flag while the last sample charges
	always_ff @(posedge clk) begin
		if (rst) begin
			charge_transfer_wait <= 1'b0;
		end else begin
			charge_transfer_wait <= (state == lars_st_readout && clock_edge && clock_count == `LARS_CNT_LAST_PIX
				&& !fs_s2) || (state == lars_st_transfer && wait_cnt != '0 && !(clock_edge && fs_s2));
		end
	end

	// checks
	AST_START_CAPTURE: assert property (clock_edge && fs_s2 |=> clock_count == `LARS_CNT_FIRST
		&& state == lars_st_setup && pixel_select[0])
		else $error("start bit not captured");
	AST_FREEZE_ON_RISE: assert property (fs_rise && !clock_edge |=> sample_freeze && integrator_reset
		&& sample_connect == '0)
		else $error("start edge did not freeze samples");
	AST_SHIFT_STEP: assert property (clock_edge |=> pixel_select == {$past(pixel_select[PIXELS-2:0]), $past(fs_s2)})
		else $error("shift register did not step");
	AST_SETUP_END: assert property (clock_edge && clock_count == `LARS_CNT_SETUP_LAST && !fs_s2 && !fs_rise
		|=> !integrator_reset && state == lars_st_readout)
		else $error("integrator reset not released at clock 19");
	AST_SETUP_HOLD: assert property (state == lars_st_setup && !(clock_edge && next_count == `LARS_CNT_INT_START)
		|=> integrator_reset)
		else $error("integrator reset dropped early");
	AST_END_HIZ: assert property (clock_edge && clock_count == `LARS_CNT_LAST_PIX && !fs_s2 && pixel_select ==
		{1'b1, {(PIXELS-1){1'b0}}} |=> !analog_pixel_out_en ##1 !analog_pixel_out_en)
		else $error("output not released at 129th edge");
	AST_HIZ_OUTSIDE: assert property (analog_pixel_out_en == (|pixel_select))
		else $error("output enabled outside pixel phase");
	AST_WAIT_LEN: assert property ($rose(charge_transfer_wait) && !fs_s2 && !fs_s1 |-> charge_transfer_wait[*8])
		else $error("charge transfer wait too short");
	AST_READOUT_EN: assert property (clock_edge && clock_count != '0 && clock_count < `LARS_CNT_LAST_PIX
		|=> analog_pixel_out_en)
		else $error("output dropped during readout");
	AST_LAST_RECONNECT: assert property (clock_edge && clock_count == `LARS_CNT_LAST_PIX && !fs_s2 && !fs_rise
		|=> sample_connect == '1)
		else $error("samples not reconnected at 129th edge");

endmodule // lars_sequencer

// ---- rtl/lars_cfg.svh ----
`ifndef LARS_CFG_SVH
`define LARS_CFG_SVH

// pixel and readout counts
`define LARS_PIXELS         128
`define LARS_CNT_W          8
`define LARS_CNT_FIRST      8'h01
`define LARS_CNT_SETUP_LAST 8'h12
`define LARS_CNT_INT_START  8'h13
`define LARS_CNT_LAST_PIX   8'h80
`define LARS_CNT_END        8'h81

// charge transfer wait in ns, system clock period in ns
`define LARS_CLK_NS         32'h0000_0014
`define LARS_TQT_NS         32'h0000_4E20
`define LARS_WAIT_W         10
`define LARS_TQT_CYCLES     ((`LARS_TQT_NS + `LARS_CLK_NS - 32'h0000_0001) / `LARS_CLK_NS)

// sequencer state codes, gray along idle-setup-readout-transfer
`define LARS_ST_IDLE        2'h0
`define LARS_ST_SETUP       2'h1
`define LARS_ST_READOUT     2'h3
`define LARS_ST_TRANSFER    2'h2

`endif

// ---- rtl/lars_pkg.sv ----
`include "lars_cfg.svh"

package lars_pkg;

	// readout sequencer phases
	typedef enum logic [1:0] {
		lars_st_idle     = `LARS_ST_IDLE,
		lars_st_setup    = `LARS_ST_SETUP,
		lars_st_readout  = `LARS_ST_READOUT,
		lars_st_transfer = `LARS_ST_TRANSFER
	} lars_state_t;

	typedef logic [`LARS_CNT_W-1:0] lars_count_t;

endpackage

// ---- sim/lars_host_model.sv ----
module lars_host_model (
	// system
	input  wire logic clk,
	// controller pins
	output logic      sensor_clk_pin,
	output logic      frame_start_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle with the sensor clock low
	initial begin
		sensor_clk_pin  = 1'b0;
		frame_start_pin = 1'b0;
	end

	// start level goes up ahead of the capturing edge
	task automatic raise_start();
		@(negedge clk) frame_start_pin <= 1'b1;
		repeat (4) @(negedge clk);
	endtask

	// one sensor clock, 4 clk high, 4 clk low; start drops with the fall
	task automatic pulse();
		@(negedge clk) sensor_clk_pin <= 1'b1;
		repeat (3) @(negedge clk);
		@(negedge clk) sensor_clk_pin <= 1'b0;
		frame_start_pin <= 1'b0;
		repeat (3) @(negedge clk);
	endtask

	// charge transfer time plus margin before another start
	task automatic transfer_wait();
		repeat (1010) @(negedge clk);
	endtask
endmodule // lars_host_model

// ---- sim/lars_sequencer_bench.sv ----
module lars_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ps;

	// design signals
	logic                  clk = 1'b0;
	logic                  rst = 1'b1;
	logic                  sensor_clk_pin;
	logic                  frame_start_pin;
	logic [127:0]          pixel_select;
	logic [127:0]          sample_connect;
	logic                  analog_pixel_out_en;
	logic                  sample_freeze;
	logic                  integrator_reset;
	logic                  charge_transfer_wait;
	lars_pkg::lars_count_t clock_count;
	// bench bookkeeping
	int                    errors = 0;
	int                    checked = 0;
	int                    cycles = 0;
	int                    run_len = 0;
	int                    last_len = 0;

	always #10 clk = ~clk;

	lars_sequencer dut_u (.clk(clk), .rst(rst), .sensor_clk_pin(sensor_clk_pin),
		.frame_start_pin(frame_start_pin), .pixel_select(pixel_select), .sample_connect(sample_connect),
		.analog_pixel_out_en(analog_pixel_out_en), .sample_freeze(sample_freeze),
		.integrator_reset(integrator_reset), .charge_transfer_wait(charge_transfer_wait),
		.clock_count(clock_count));

	lars_host_model host_u (.clk(clk), .sensor_clk_pin(sensor_clk_pin), .frame_start_pin(frame_start_pin));

	// length of each transfer wait pulse, and hang guard
	always @(posedge clk) begin
		cycles++;
		if (charge_transfer_wait) run_len++;
		else if (run_len != 0) begin
			last_len = run_len;
			run_len  = 0;
		end
		if (cycles == 12000) begin
			errors++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(input logic [127:0] got, input logic [127:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask

	// idle outputs, during and after reset
	task automatic check_idle();
		check(pixel_select, 128'h0, "select idle");
		check(sample_connect, '1, "connect idle");
		check(analog_pixel_out_en, 1'b0, "output idle");
		check({sample_freeze, integrator_reset, charge_transfer_wait}, 3'h0, "flags idle");
		check(clock_count, 8'h00, "count idle");
	endtask

	// one whole readout cycle checked edge by edge
	task automatic test_frame();
		host_u.raise_start();
		check({sample_freeze, integrator_reset}, 2'h3, "freeze and reset");
		check(sample_connect, 128'h0, "all samples held");
		for (int k = 1; k <= 129; k++) begin
			host_u.pulse();
			check(pixel_select, (k <= 128) ? 128'h1 << (k - 1) : 128'h0, "select");
			check(analog_pixel_out_en, k <= 128, "output enable");
			check(clock_count, k, "count");
			check(integrator_reset, k < 19, "integrator reset");
			check(sample_connect, (k == 129) ? '1 : (k >= 19) ? (128'h1 << (k - 1)) - 1 : 0, "connect");
			check(sample_freeze, 1'b0, "freeze released");
		end
		check(charge_transfer_wait, 1'b1, "transfer wait");
		host_u.transfer_wait();
		check(charge_transfer_wait, 1'b0, "transfer wait over");
		check(last_len, 1000, "transfer wait length");
		$display("frame test done");
	endtask

	// reset in the setup phase returns to idle
	task automatic test_midreset();
		host_u.raise_start();
		repeat (5) host_u.pulse();
		check(clock_count, 8'h05, "count before reset");
		rst <= 1'b1;
		repeat (2) @(negedge clk);
		rst <= 1'b0;
		check_idle();
		$display("mid reset test done");
	endtask

	initial begin
		repeat (10) @(negedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check_idle();
		test_frame();
		test_frame();
		test_midreset();
		test_frame();
		report_and_stop();
	end
endmodule // lars_sequencer_bench
